// ==== hw/tmo_thermal_overload.sv ====
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
// Summary of operation
// - Eight setting groups; the active one is chosen by one group select field.
// - Block input and group select may change at any time; next pass uses them.
// - Each tick runs input, replica, comparator, block check and output stages.
// - Every output change emits a time-stamped ON or OFF event, 1 ms resolution.
// - Trip, alarm1, alarm2, inhibit and blocked ON events are counted; clearable.
// - Outputs are given both as relay outputs and as logic operands.
// - Phase currents are true RMS values over 32 harmonic components.
// - Three phase, positive and negative sequence currents arrive every 5 ms.
// - Ambient temperature arrives every 5 ms and corrects the thermal image.
// - Node mode codes 1 on to 5 off, default on, writable only when allowed.
// - Function enable 0 disabled, 1 activated; resets to disabled.
// - Forcing codes 1 to 5 override state only when forcing is enabled; code 0 is normal.
// - Temperatures are shown in Celsius for code 0, Fahrenheit for code 1.
// - Nominal current also held in primary amperes, 0.1 A resolution.
// - With dual time constants the replica picks its curve automatically.
// - With dual time constants, current above maximum overload setting selects the stall constant, heating with shift 2 instead of 6.
module tmo_thermal_overload #(
	parameter int MS_CYCLES_P = tmo_pkg::MS_CYCLES
) (
	// Clock, reset and clock enable.
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// Avalon-MM slave.
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Measurements from the pre-processing logic, same clock.
	input wire logic meas_valid,
	input wire tmo_pkg::tmo_meas_t meas,
	// User logic.
	input wire logic block_in,
	output tmo_pkg::tmo_flags_t relay_out,
	output tmo_pkg::tmo_flags_t logic_operand,
	output logic [15:0] thermal_level,
	// Event stream.
	input wire logic evt_ready,
	output logic evt_valid,
	output tmo_pkg::tmo_event_t evt_data
);
	import tmo_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_REPLICA, ST_COMPARE, ST_BLOCK, ST_OUTPUT
	} tmo_stage_t;

	typedef struct packed {
		logic waitreq;
		logic [31:0] rdata;
		logic en;
		logic [2:0] logical_node_state;
		logic [2:0] force_sel;
		logic unit_f;
		logic [2:0] grp;
		logic force_allow;
		logic ln_allow;
		logic dual_tc;
		logic [NUM_GROUPS-1:0][NUM_SET-1:0][15:0] sets;
		tmo_meas_t m;
		tmo_stage_t st;
		logic [15:0] heat;
		logic [15:0] level;
		logic stall;
		tmo_flags_t raw;
		logic blk;
		tmo_flags_t out;
		logic [NUM_EVT-1:0] clr;
	} tmo_state_t;

	tmo_state_t s_q, s_d;
	logic [NUM_EVT-1:0][15:0] counts;
	logic req;
	logic [NUM_SET-1:0][15:0] act;
	logic [15:0] imax;
	logic [16:0] ieq;
	logic [16:0] heat_sum;
	logic [22:0] rise;
	logic [16:0] lvl_sum;
	logic [15:0] amb_excess;
	logic [15:0] ctrl_word;
	logic [8:0] goff;
	logic [2:0] gidx;
	logic [2:0] kidx;
	logic running;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// Celsius to display unit; Fahrenheit is c * 9 / 5 + 32.
	function automatic logic [15:0] to_unit(input logic signed [15:0] c, input logic f);
		logic signed [31:0] t;
		t = 32'(c);
		if (f) begin
			t = (t * 32'sd9) / 32'sd5 + 32'sd32;
		end
		return t[15:0];
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.clr = '0;
		req = avs_read || avs_write;
		// Active group from the common selector.
		act = s_q.sets[s_q.grp];
		goff = avs_address - REG_GRP_BASE;
		gidx = goff[7:5];
		kidx = goff[4:2];
		ctrl_word = '0;
		ctrl_word[CTRL_EN_BIT] = s_q.en;
		ctrl_word[CTRL_LN_LSB +: 3] = s_q.logical_node_state;
		ctrl_word[CTRL_FORCE_LSB +: 3] = s_q.force_sel;
		ctrl_word[CTRL_UNIT_BIT] = s_q.unit_f;
		ctrl_word[CTRL_GRP_LSB +: 3] = s_q.grp;
		ctrl_word[CTRL_FORCE_ALLOW_BIT] = s_q.force_allow;
		ctrl_word[CTRL_LN_ALLOW_BIT] = s_q.ln_allow;
		ctrl_word[CTRL_DUAL_TC_BIT] = s_q.dual_tc;

		// Slave answers one cycle after the request; the answer edge carries the write.
		s_d.waitreq = 1'b1;
		if (req && s_q.waitreq) begin
			s_d.waitreq = 1'b0;
			s_d.rdata = 32'h0;
			if (avs_address == REG_CTRL) begin
				s_d.rdata = {16'h0, ctrl_word};
			end else if (avs_address == REG_STATUS) begin
				s_d.rdata = {23'h0, s_q.grp, s_q.stall, s_q.out};
			end else if (avs_address == REG_LEVEL) begin
				s_d.rdata = {16'h0, s_q.level};
			end else if (avs_address == REG_TEMP_AMB) begin
				s_d.rdata = {16'h0, to_unit(s_q.m.ambient_temp, s_q.unit_f)};
			end else if (avs_address == REG_TEMP_IMG) begin
				s_d.rdata = {16'h0, to_unit(s_q.m.ambient_temp +
					16'(s_q.level >> IMG_TEMP_SHIFT), s_q.unit_f)};
			end else if (avs_address >= REG_CNT_BASE &&
					avs_address < REG_CNT_BASE + 9'(4 * NUM_EVT) && avs_address[1:0] == 2'h0) begin
				s_d.rdata = {16'h0, counts[3'((avs_address - REG_CNT_BASE) >> 2)]};
			end else if (avs_address >= REG_GRP_BASE && goff < 9'(NUM_GROUPS) * REG_GRP_STRIDE &&
					kidx < 3'(NUM_SET) && goff[1:0] == 2'h0) begin
				s_d.rdata = {16'h0, s_q.sets[gidx][kidx]};
			end
		end
		if (avs_write && !s_q.waitreq) begin
			if (avs_address == REG_CTRL && avs_byteenable[0]) begin
				s_d.en = avs_writedata[CTRL_EN_BIT];
				s_d.force_sel = avs_writedata[CTRL_FORCE_LSB +: 3];
				s_d.unit_f = avs_writedata[CTRL_UNIT_BIT];
				// Node mode only when individual mode setting is allowed.
				if (s_q.ln_allow && avs_writedata[CTRL_LN_LSB +: 3] >= 3'(TMO_LN_ON) &&
						avs_writedata[CTRL_LN_LSB +: 3] <= 3'(TMO_LN_OFF)) begin
					s_d.logical_node_state = avs_writedata[CTRL_LN_LSB +: 3];
				end
			end
			if (avs_address == REG_CTRL && avs_byteenable[1]) begin
				// Group switch takes effect on the next pass, no stop.
				s_d.grp = avs_writedata[CTRL_GRP_LSB +: 3];
				s_d.force_allow = avs_writedata[CTRL_FORCE_ALLOW_BIT];
				s_d.ln_allow = avs_writedata[CTRL_LN_ALLOW_BIT];
				s_d.dual_tc = avs_writedata[CTRL_DUAL_TC_BIT];
			end
			// Write one to clear a counter.
			if (avs_address == REG_CNT_CLR && avs_byteenable[0]) begin
				s_d.clr = avs_writedata[NUM_EVT-1:0];
			end
			// Group words, nominal current per unit and in amperes.
			if (avs_address >= REG_GRP_BASE && goff < 9'(NUM_GROUPS) * REG_GRP_STRIDE &&
					kidx < 3'(NUM_SET) && goff[1:0] == 2'h0) begin
				s_d.sets[gidx][kidx] = merge16(s_q.sets[gidx][kidx], avs_writedata,
					avs_byteenable);
			end
		end

		imax = s_q.m.phase_a_rms_current;
		if (s_q.m.phase_b_rms_current > imax) begin
			imax = s_q.m.phase_b_rms_current;
		end
		if (s_q.m.phase_c_rms_current > imax) begin
			imax = s_q.m.phase_c_rms_current;
		end
		// Negative sequence adds rotor heating on top of the worst phase.
		ieq = {1'b0, imax} + {1'b0, s_q.m.neg_seq_current};
		running = s_q.m.pos_seq_current > (act[SET_NOM_PU] >> 3);
		heat_sum = {1'b0, s_q.heat};
		rise = 23'h0;
		amb_excess = 16'h0;
		// Ambient above reference raises the image.
		if (s_q.m.ambient_temp > AMB_REF_C) begin
			amb_excess = 16'(s_q.m.ambient_temp - AMB_REF_C);
		end
		lvl_sum = {1'b0, s_q.heat} + {1'b0, amb_excess};

		unique case (s_q.st)
			ST_IDLE: begin
				if (meas_valid) begin
					// Latch the 5 ms RMS and sequence currents.
					s_d.m = meas;
					s_d.st = ST_REPLICA;
				end
			end
			ST_REPLICA: begin
				// Stall constant above the maximum overload current.
				s_d.stall = s_q.dual_tc && ieq > {1'b0, act[SET_MAX_OVL]};
				if (ieq > {1'b0, act[SET_NOM_PU]}) begin
					// The rise is kept wide so that a huge overcurrent saturates instead of wrapping.
					rise = 23'(ieq - {1'b0, act[SET_NOM_PU]});
					if (s_d.stall) begin
						rise = rise << STALL_SHIFT;
					end else begin
						rise = rise << HEAT_SHIFT;
					end
					if (rise[22:16] != 7'h0) begin
						heat_sum = 17'h10000;
					end else begin
						heat_sum = {1'b0, s_q.heat} + {1'b0, rise[15:0]};
					end
					s_d.heat = heat_sum[16] ? 16'hffff : heat_sum[15:0];
				end else begin
					// Slower cooling once the motor stands still, with dual time constants only.
					if (running || !s_q.dual_tc) begin
						heat_sum = {1'b0, s_q.heat >> COOL_RUN_SHIFT};
					end else begin
						heat_sum = {1'b0, s_q.heat >> COOL_STOP_SHIFT};
					end
					s_d.heat = s_q.heat - (heat_sum[15:0] == 16'h0 && s_q.heat != 16'h0 ?
						16'h1 : heat_sum[15:0]);
				end
				s_d.st = ST_COMPARE;
			end
			ST_COMPARE: begin
				s_d.level = lvl_sum[16] ? 16'hffff : lvl_sum[15:0];
				s_d.raw.trip = s_d.level >= act[SET_TRIP];
				s_d.raw.alarm1 = s_d.level >= act[SET_ALARM1];
				s_d.raw.alarm2 = s_d.level >= act[SET_ALARM2];
				s_d.raw.inhibit = s_d.level >= act[SET_INHIBIT];
				s_d.raw.blocked = 1'b0;
				s_d.st = ST_BLOCK;
			end
			ST_BLOCK: begin
				// Live block input or blocking modes.
				s_d.blk = block_in || s_q.logical_node_state == TMO_LN_BLOCKED ||
					s_q.logical_node_state == TMO_LN_TEST_BLOCKED || s_q.logical_node_state == TMO_LN_OFF;
				s_d.st = ST_OUTPUT;
			end
			ST_OUTPUT: begin
				s_d.out = '0;
				if (s_q.en) begin
					if (s_q.force_allow && s_q.force_sel != TMO_FORCE_NORMAL) begin
						s_d.out.blocked = s_q.force_sel == TMO_FORCE_BLOCKED;
						s_d.out.alarm1 = s_q.force_sel == TMO_FORCE_ALARM1;
						s_d.out.alarm2 = s_q.force_sel == TMO_FORCE_ALARM2;
						s_d.out.inhibit = s_q.force_sel == TMO_FORCE_INHIBIT;
						s_d.out.trip = s_q.force_sel == TMO_FORCE_TRIP;
					end else if (s_q.blk) begin
						s_d.out.blocked = 1'b1;
					end else begin
						s_d.out = s_q.raw;
					end
				end
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.waitreq <= 1'b1;
			s_q.logical_node_state <= TMO_LN_ON;
			s_q.st <= ST_IDLE;
			for (int g = 0; g < NUM_GROUPS; g++) begin
				s_q.sets[g][SET_NOM_PU] <= RST_NOM_PU;
				s_q.sets[g][SET_NOM_AMP] <= RST_NOM_AMP;
				s_q.sets[g][SET_MAX_OVL] <= RST_MAX_OVL;
				s_q.sets[g][SET_ALARM1] <= RST_ALARM1;
				s_q.sets[g][SET_ALARM2] <= RST_ALARM2;
				s_q.sets[g][SET_INHIBIT] <= RST_INHIBIT;
				s_q.sets[g][SET_TRIP] <= RST_TRIP;
			end
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	tmo_event_unit #(
		.MS_CYCLES_P(MS_CYCLES_P)
	) u_events (
		.ref_clk(ref_clk),
		.srst(srst),
		.ce(ce),
		.flags(s_q.out),
		.cnt_clr(s_q.clr),
		.evt_ready(evt_ready),
		.evt_valid(evt_valid),
		.evt_data(evt_data),
		.counts(counts)
	);

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	// Same flags to relay outputs and to logic operands.
	assign relay_out = s_q.out;
	assign logic_operand = s_q.out;
	assign thermal_level = s_q.level;
endmodule

// ==== hw/tmo_pkg.sv ====
package tmo_pkg;
	// Clock and time base.
	localparam int CLK_PERIOD_NS = 25;
	localparam int TS_RES_NS = 1000000;
	localparam int MS_CYCLES = (TS_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MEAS_PERIOD_MS = 5;

	// Sizes.
	localparam int NUM_GROUPS = 8;
	localparam int NUM_SET = 7;
	localparam int NUM_EVT = 5;

	// Register byte offsets.
	localparam logic [8:0] REG_CTRL = 9'h000;
	localparam logic [8:0] REG_STATUS = 9'h004;
	localparam logic [8:0] REG_LEVEL = 9'h008;
	localparam logic [8:0] REG_TEMP_AMB = 9'h00c;
	localparam logic [8:0] REG_TEMP_IMG = 9'h010;
	localparam logic [8:0] REG_CNT_CLR = 9'h014;
	localparam logic [8:0] REG_CNT_BASE = 9'h018;
	localparam logic [8:0] REG_GRP_BASE = 9'h040;
	localparam logic [8:0] REG_GRP_STRIDE = 9'h020;

	// Control register fields.
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_LN_LSB = 1;
	localparam int CTRL_FORCE_LSB = 4;
	localparam int CTRL_UNIT_BIT = 7;
	localparam int CTRL_GRP_LSB = 8;
	localparam int CTRL_FORCE_ALLOW_BIT = 11;
	localparam int CTRL_LN_ALLOW_BIT = 12;
	localparam int CTRL_DUAL_TC_BIT = 13;

	// Setting word index inside one group.
	localparam int SET_NOM_PU = 0;
	localparam int SET_NOM_AMP = 1;
	localparam int SET_MAX_OVL = 2;
	localparam int SET_ALARM1 = 3;
	localparam int SET_ALARM2 = 4;
	localparam int SET_INHIBIT = 5;
	localparam int SET_TRIP = 6;

	// Setting reset values; currents in tenths of per unit or tenths of ampere.
	localparam logic [15:0] RST_NOM_PU = 16'h000a;
	localparam logic [15:0] RST_NOM_AMP = 16'h000a;
	localparam logic [15:0] RST_MAX_OVL = 16'h0014;
	localparam logic [15:0] RST_ALARM1 = 16'h5000;
	localparam logic [15:0] RST_ALARM2 = 16'h6000;
	localparam logic [15:0] RST_INHIBIT = 16'h7000;
	localparam logic [15:0] RST_TRIP = 16'h8000;

	// Replica shaping constants.
	localparam int HEAT_SHIFT = 6;
	localparam int STALL_SHIFT = 2;
	localparam int COOL_RUN_SHIFT = 6;
	localparam int COOL_STOP_SHIFT = 8;
	localparam logic signed [15:0] AMB_REF_C = 16'sh0028;
	localparam int IMG_TEMP_SHIFT = 9;

	typedef enum logic [2:0] {
		TMO_LN_ON = 3'h1, TMO_LN_BLOCKED = 3'h2, TMO_LN_TEST = 3'h3,
		TMO_LN_TEST_BLOCKED = 3'h4, TMO_LN_OFF = 3'h5
	} tmo_logical_node_state_t;

	typedef enum logic [2:0] {
		TMO_FORCE_NORMAL = 3'h0, TMO_FORCE_BLOCKED = 3'h1, TMO_FORCE_ALARM1 = 3'h2,
		TMO_FORCE_ALARM2 = 3'h3, TMO_FORCE_INHIBIT = 3'h4, TMO_FORCE_TRIP = 3'h5
	} tmo_force_t;

	// Measurement bundle refreshed every 5 ms; temperature is signed degrees Celsius.
	typedef struct packed {
		logic [15:0] phase_a_rms_current;
		logic [15:0] phase_b_rms_current;
		logic [15:0] phase_c_rms_current;
		logic [15:0] pos_seq_current;
		logic [15:0] neg_seq_current;
		logic signed [15:0] ambient_temp;
	} tmo_meas_t;

	// Bit 0 is trip, bit 4 is blocked.
	typedef struct packed {
		logic blocked;
		logic inhibit;
		logic alarm2;
		logic alarm1;
		logic trip;
	} tmo_flags_t;

	typedef struct packed {
		logic [31:0] stamp_ms;
		logic [2:0] source;
		logic on;
	} tmo_event_t;
endpackage

// ==== hw/tmo_event_unit.sv ====
`timescale 1ns/100ps
module tmo_event_unit #(
	parameter int MS_CYCLES_P = tmo_pkg::MS_CYCLES
) (
	// Clock and control.
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// Output flags and counter clears.
	input wire tmo_pkg::tmo_flags_t flags,
	input wire logic [tmo_pkg::NUM_EVT-1:0] cnt_clr,
	// Event stream towards the shared buffer.
	input wire logic evt_ready,
	output logic evt_valid,
	output tmo_pkg::tmo_event_t evt_data,
	// Cumulative counters.
	output logic [tmo_pkg::NUM_EVT-1:0][15:0] counts
);
	import tmo_pkg::*;

	typedef struct packed {
		logic [31:0] presc;
		logic [31:0] stamp;
		logic [NUM_EVT-1:0] reported;
		logic valid;
		tmo_event_t ev;
		logic [NUM_EVT-1:0][15:0] cnt;
	} tmo_ev_state_t;

	tmo_ev_state_t s_q, s_d;
	logic [NUM_EVT-1:0] diff;
	logic found;

	always_comb begin
		s_d = s_q;
		diff = flags ^ s_q.reported;
		found = 1'b0;
		if (s_q.presc == 32'(MS_CYCLES_P - 1)) begin
			s_d.presc = 32'h0;
			s_d.stamp = s_q.stamp + 32'h1;
		end else begin
			s_d.presc = s_q.presc + 32'h1;
		end
		if (s_q.valid && evt_ready) begin
			s_d.valid = 1'b0;
		end
		for (int i = 0; i < NUM_EVT; i++) begin
			if (cnt_clr[i]) begin
				s_d.cnt[i] = 16'h0;
			end
		end
		// ON and OFF events, one per cycle, lowest source first.
		if (!s_q.valid || evt_ready) begin
			for (int i = 0; i < NUM_EVT; i++) begin
				if (diff[i] && !found) begin
					found = 1'b1;
					s_d.valid = 1'b1;
					s_d.ev.stamp_ms = s_q.stamp;
					s_d.ev.source = 3'(i);
					s_d.ev.on = flags[i];
					s_d.reported[i] = flags[i];
					// Count ON events; a count in the clear cycle survives.
					if (flags[i]) begin
						s_d.cnt[i] = (cnt_clr[i] ? 16'h0 : s_q.cnt[i]) + 16'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign evt_valid = s_q.valid;
	assign evt_data = s_q.ev;
	assign counts = s_q.cnt;
endmodule

// ==== sim/tmo_monitor.sv ====
`timescale 1ns/100ps
module tmo_monitor
	import tmo_pkg::*;
#(
	parameter int MS_CYCLES_P = tmo_pkg::MS_CYCLES
) (
	// Clock, reset and clock enable.
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// Avalon-MM slave.
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Measurements and user logic.
	input wire logic meas_valid,
	input wire tmo_pkg::tmo_meas_t meas,
	input wire logic block_in,
	input wire tmo_pkg::tmo_flags_t relay_out,
	input wire tmo_pkg::tmo_flags_t logic_operand,
	input wire logic [15:0] thermal_level,
	// Event stream.
	input wire logic evt_ready,
	input wire logic evt_valid,
	input wire tmo_pkg::tmo_event_t evt_data
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	wait_one_a: assert property (
		ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one wait cycle");
	answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer longer than one cycle");
	no_spurious_a: assert property (
		!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer without request");
	read_upper_a: assert property (
		!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	outputs_same_a: assert property (relay_out == logic_operand)
		else $error("relay outputs and logic operands differ");
	blocked_only_a: assert property (relay_out.blocked |-> relay_out[3:0] == 4'h0)
		else $error("other flags active while blocked");
	event_hold_a: assert property (
		evt_valid && !evt_ready |=> evt_valid && $stable(evt_data))
		else $error("event dropped or changed before acceptance");
	event_raise_a: assert property (relay_out != $past(relay_out) |=> evt_valid)
		else $error("no event after output change");
	flag_pass_a: assert property (relay_out != $past(relay_out) |->
		$past(meas_valid, 4) || $past(meas_valid, 5) || $past(meas_valid, 6) ||
		$past(meas_valid, 7))
		else $error("outputs changed outside a processing pass");
	level_pass_a: assert property (thermal_level != $past(thermal_level) |->
		$past(meas_valid, 2) || $past(meas_valid, 3) || $past(meas_valid, 4) ||
		$past(meas_valid, 5))
		else $error("level changed outside a processing pass");
endmodule
bind tmo_thermal_overload tmo_monitor #(.MS_CYCLES_P(MS_CYCLES_P)) mon (
	.ref_clk(ref_clk), .srst(srst), .ce(ce), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .meas_valid(meas_valid), .meas(meas),
	.block_in(block_in), .relay_out(relay_out), .logic_operand(logic_operand),
	.thermal_level(thermal_level), .evt_ready(evt_ready), .evt_valid(evt_valid),
	.evt_data(evt_data));

// ==== sim/tmo_evt_sink.sv ====
`timescale 1ns/100ps
module tmo_evt_sink
	import tmo_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic srst,
	// Event stream from the function.
	input wire logic evt_valid,
	input wire tmo_pkg::tmo_event_t evt_data,
	output logic evt_ready
);
	int seed = 32'hd6c56b9a;
	tmo_event_t got[$];
	// Stalling event buffer.
	// Random stalls make the function hold each event until it is taken.
	always @(posedge ref_clk) begin
		if (!srst && evt_valid && evt_ready)
			got.push_back(evt_data);
		evt_ready <= srst ? 1'b0 : 1'($random(seed));
	end
endmodule

// ==== sim/tb_tmo_thermal_overload.sv ====
`timescale 1ns/100ps
module tb_tmo_thermal_overload;
	import tmo_pkg::*;
	logic ref_clk, srst, ce, avs_read, avs_write, avs_waitrequest, meas_valid, block_in;
	logic evt_ready, evt_valid;
	logic [8:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	tmo_meas_t meas;
	tmo_flags_t relay_out, logic_operand;
	logic [15:0] thermal_level;
	tmo_event_t evt_data;
	int error_cnt, compares, seed, heat, amb, ncyc, g, k, last;
	int thr[8][4];
	int cnt[5];
	logic [15:0] dflt[7] = '{RST_NOM_PU, RST_NOM_AMP, RST_MAX_OVL, RST_ALARM1, RST_ALARM2,
		RST_INHIBIT, RST_TRIP};
	logic [4:0] fl;
	logic en_m, fa_m, la_m, dt_m;
	logic [2:0] grp_m, fs_m, ln_m;
	tmo_event_t exp_q[$];

	tmo_thermal_overload #(.MS_CYCLES_P(10)) DUT (.ref_clk(ref_clk), .srst(srst), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.meas_valid(meas_valid), .meas(meas), .block_in(block_in), .relay_out(relay_out),
		.logic_operand(logic_operand), .thermal_level(thermal_level),
		.evt_ready(evt_ready), .evt_valid(evt_valid), .evt_data(evt_data));
	tmo_evt_sink PART (.ref_clk(ref_clk), .srst(srst), .evt_valid(evt_valid),
		.evt_data(evt_data), .evt_ready(evt_ready));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) ncyc++;

	task print_verdict();
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; the request is held until waitrequest is sampled low.
	task bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		if (avs_waitrequest !== 1'b0) begin
			error_cnt++;
			print_verdict();
		end else begin
			rd = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask

	function logic [31:0] cw(input logic [2:0] ln, input logic unit);
		return {18'h0, dt_m, la_m, fa_m, grp_m, unit, fs_m, ln, en_m};
	endfunction

	// Node mode only moves when the allow bit was already set and the code is legal.
	task wctrl(input logic [2:0] ln, input logic unit);
		bus(1'b1, REG_CTRL, cw(ln, unit));
		if (DUT.srst === 1'b0 && last == 1 && ln >= 3'h1 && ln <= 3'h5)
			ln_m = ln;
		last = la_m;
	endtask

	function logic [4:0] exp_flags(input int lvl);
		if (!en_m)
			return 5'h00;
		if (fa_m && fs_m != 3'h0)
			return (fs_m == 3'h1) ? 5'h10 : (fs_m == 3'h5) ? 5'h01 : 5'(1 << (fs_m - 1));
		if (block_in || ln_m == 3'h2 || ln_m == 3'h4 || ln_m == 3'h5)
			return 5'h10;
		return {1'b0, lvl >= thr[grp_m][2], lvl >= thr[grp_m][1], lvl >= thr[grp_m][0],
			lvl >= thr[grp_m][3]};
	endfunction

	task pass(input int cur, input int a, input logic blk);
		int lvl, i, sh;
		logic [4:0] f;
		@(posedge ref_clk);
		meas <= {16'(cur), 16'(cur), 16'(cur), 16'(cur), 16'h0000, 16'(a)};
		meas_valid <= 1'b1;
		block_in <= blk;
		@(posedge ref_clk);
		meas_valid <= 1'b0;
		amb = a;
		// Above 1.00 per unit the image heats, with the stall constant above 2.0 in dual mode.
		if (cur > 10)
			heat += (cur - 10) << ((dt_m && cur > 20) ? STALL_SHIFT : HEAT_SHIFT);
		else begin
			sh = (dt_m && cur <= 1) ? COOL_STOP_SHIFT : COOL_RUN_SHIFT;
			heat -= ((heat >> sh) == 0 && heat != 0) ? 1 : heat >> sh;
		end
		lvl = heat + ((a > 40) ? a - 40 : 0);
		repeat (26) @(posedge ref_clk);
		chk({16'h0, thermal_level}, 32'(lvl));
		f = exp_flags(lvl);
		chk({27'h0, relay_out}, {27'h0, f});
		for (i = 0; i < 5; i++) begin
			if (f[i] != fl[i]) begin
				exp_q.push_back({32'h0, 3'(i), f[i]});
				if (f[i])
					cnt[i]++;
			end
		end
		fl = f;
	endtask

	initial begin
		seed = 32'hd6c56b9a;
		{avs_read, avs_write, meas_valid, block_in, avs_address, avs_writedata} = '0;
		meas = '0;
		avs_byteenable = 4'h3;
		ce = 1'b1;
		srst = 1'b1;
		{en_m, fa_m, la_m, dt_m, grp_m, fs_m, fl} = '0;
		ln_m = 3'h1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		bus(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0000_0002);
		bus(1'b0, 9'h1fc, 32'h0);
		chk(rd, 32'h0);
		for (g = 0; g < 8; g++) begin
			for (k = 0; k < 7; k++) begin
				bus(1'b0, 9'(REG_GRP_BASE + g * REG_GRP_STRIDE + k * 4), 32'h0);
				chk(rd, {16'h0, dflt[k]});
			end
			for (k = 3; k < 7; k++) begin
				thr[g][k - 3] = 150 * (k - 2) + 40 * g;
				bus(1'b1, 9'(REG_GRP_BASE + g * REG_GRP_STRIDE + k * 4), 32'(thr[g][k - 3]));
				bus(1'b0, 9'(REG_GRP_BASE + g * REG_GRP_STRIDE + k * 4), 32'h0);
				chk(rd, 32'(thr[g][k - 3]));
			end
			bus(1'b1, 9'(REG_GRP_BASE + g * REG_GRP_STRIDE), 32'h000a);
		end
		en_m = 1'b1;
		for (k = 0; k < 12; k++) begin
			grp_m = 3'($random(seed));
			wctrl(ln_m, 1'b0);
			pass(11 + ($random(seed) & 3), 30 + ($random(seed) & 31), ($random(seed) & 3) == 0);
		end
		fa_m = 1'b1;
		for (k = 1; k < 7; k++) begin
			fs_m = 3'(k % 6);
			wctrl(ln_m, 1'b0);
			pass(11, 35, 1'b0);
		end
		fa_m = 1'b0;
		fs_m = 3'h5;
		wctrl(ln_m, 1'b0);
		pass(11, 35, 1'b0);
		fs_m = 3'h0;
		wctrl(3'h5, 1'b0);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(rd, cw(3'h1, 1'b0));
		la_m = 1'b1;
		wctrl(ln_m, 1'b0);
		wctrl(3'h2, 1'b0);
		pass(11, 60, 1'b0);
		wctrl(3'h5, 1'b0);
		pass(11, 60, 1'b0);
		wctrl(3'h4, 1'b0);
		pass(11, 60, 1'b0);
		wctrl(3'h3, 1'b0);
		pass(11, 60, 1'b0);
		wctrl(3'h7, 1'b0);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(rd, cw(3'h3, 1'b0));
		wctrl(3'h1, 1'b0);
		pass(11, 60, 1'b0);
		wctrl(ln_m, 1'b1);
		bus(1'b0, REG_TEMP_AMB, 32'h0);
		chk(rd, 32'(amb * 9 / 5 + 32));
		wctrl(ln_m, 1'b0);
		bus(1'b0, REG_TEMP_AMB, 32'h0);
		chk(rd, 32'(amb));
		// Cooling constants stay at their fixed ratio; only the dual choice is driven.
		dt_m = 1'b1;
		wctrl(ln_m, 1'b0);
		pass(30, 35, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rd, {23'h0, grp_m, 1'b1, fl});
		pass(0, 35, 1'b0);
		pass(5, 35, 1'b0);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rd, {23'h0, grp_m, 1'b0, fl});
		bus(1'b0, REG_LEVEL, 32'h0);
		chk(rd, 32'(heat));
		bus(1'b0, REG_TEMP_IMG, 32'h0);
		chk(rd, 32'(amb + (heat >> 9)));
		// Clock enable low freezes the pipeline, so this measurement pulse is lost.
		@(posedge ref_clk);
		ce <= 1'b0;
		meas_valid <= 1'b1;
		@(posedge ref_clk);
		meas_valid <= 1'b0;
		repeat (8) @(posedge ref_clk);
		ce <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk({16'h0, thermal_level}, 32'(heat));
		for (k = 0; k < 500 && PART.got.size() < exp_q.size(); k++)
			@(posedge ref_clk);
		chk(PART.got.size(), exp_q.size());
		last = 0;
		for (k = 0; k < exp_q.size() && k < PART.got.size(); k++) begin
			chk(PART.got[k][3:0], exp_q[k][3:0]);
			chk(PART.got[k].stamp_ms >= last && PART.got[k].stamp_ms <= ncyc / 10, 1);
			last = PART.got[k].stamp_ms;
		end
		for (k = 0; k < 5; k++) begin
			bus(1'b0, 9'(REG_CNT_BASE + k * 4), 32'h0);
			chk(rd, 32'(cnt[k]));
		end
		bus(1'b1, REG_CNT_CLR, 32'h1f);
		for (k = 0; k < 5; k++) begin
			bus(1'b0, 9'(REG_CNT_BASE + k * 4), 32'h0);
			chk(rd, 32'h0);
		end
		print_verdict();
	end
endmodule
